// ==== bgsf_apb_host.sv ====
/*
  APB host model for the battery gauge status block: runs one read or
  write transfer per call of its task.
  Assumes one pclk domain and presetn released before the first call.
*/
`timescale 1ns/100ps
module bgsf_apb_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // no cycle limit here: a hung slave is cut short by the bench timeout
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show the inverse so stale values are not trusted
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule

// ==== bgsf_pkg.sv ====
/*
  Shared constants for the battery gauge status and flag block: register
  byte offsets, flag bit positions, reset values and the encoding limits.
  Assumes a 32-bit APB register bus with one aligned word per register.
*/
package bgsf_pkg;
  localparam logic [7:0] OFF_FLAGS_ONE = 8'h00;
  localparam logic [7:0] OFF_FLAGS_TWO = 8'h04;
  localparam logic [7:0] OFF_TEMP_GAUGE = 8'h08;
  localparam logic [7:0] OFF_CYCLES = 8'h0C;
  localparam logic [7:0] OFF_CHARGE_WRITE = 8'h10;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h1C;

  // flags_reg_one bit positions
  localparam int F1_FINAL_LOW = 0;
  localparam int F1_FIRST_LOW = 1;
  localparam int F1_VALID_DIS = 3;
  localparam int F1_CAP_INACC = 4;
  localparam int F1_REMOVED = 5;
  localparam int F1_REPLACED = 6;
  localparam int F1_CHG = 7;
  // flags_reg_two bit positions
  localparam int F2_OVLD = 0;
  localparam int F2_RATE = 7;
  // temp_and_gauge_reg field positions
  localparam int TG_GAUGE_LSB = 0;
  localparam int TG_TEMP_LSB = 4;

  // interrupt status bit positions
  localparam int IRQ_FIRST_LOW = 0;
  localparam int IRQ_FINAL_LOW = 1;
  localparam int IRQ_REMOVED = 2;
  localparam int IRQ_OVLD = 3;
  localparam int IRQ_W = 4;

  localparam logic RST_REPLACED = 1'b1;
  localparam logic [3:0] GAUGE_MAX = 4'hF;
  localparam int GAUGE_STEPS = 16;
  localparam logic [3:0] TEMP_MAX = 4'hC;
  localparam int TEMP_BASE_C = -30;
  localparam int TEMP_BAND_C = 10;
  localparam int INACC_CYCLES = 64;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

// ==== bgsf_status_flags.sv ====
/*
  Status, flag and fuel-gauge logic of a battery capacity monitor, read
  and partly written over an APB slave port.
  Assumes analog comparators, the charge counter and temperature sensor
  deliver levels already synchronous to pclk.
*/
`timescale 1ns/100ps

// Notes on behaviour
// - first low-voltage flag sets below first threshold, clears on charging
// - final low-voltage flag sets and holds below final threshold
// - final low-voltage flag holds until charging, then clears
// - gauge level sits in low four bits of temp_and_gauge_reg
// - gauge step n means capacity between n/16 and (n+1)/16 of full
// - gauge full reference is last discharge or programmed count, by strap
// - temperature step runs 0 when coldest up to 12 above 80 C
// - overload bit follows sense voltage above overload threshold
// - charging shown while charge flows in, else discharging
// - charge rate bit in flags_reg_two tells fast from trickle
// - removed flag sets on removal condition, clears on replacement
// - replaced flag sets on return; clears on first low level or full
// - valid discharge sets only after charge reaches last discharge
// - host write of available charge disqualifies next capacity update
// - capacity inaccurate set when no update within last 64 cycles
// - cycle counter clears when charge reaches discharge after update
module bgsf_status_flags #(
  parameter int CW = 16,
  parameter int CYC_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic below_first_threshold,
  input wire logic below_final_threshold,
  input wire logic over_overload_threshold,
  input wire logic charge_flowing_in,
  input wire logic fast_charge,
  input wire logic removed_condition,
  input wire logic valid_condition,
  input wire logic capacity_updated,
  input wire logic full_ref_programmed,
  input wire logic [CW-1:0] available_charge_count,
  input wire logic [CW-1:0] last_measured_discharge,
  input wire logic [CW-1:0] programmed_full_count,
  input wire logic signed [7:0] temperature_c,
  output logic irq,
  output logic charge_load,
  output logic [CW-1:0] charge_load_value
);

  logic first_low_voltage_flag_q;
  logic final_low_voltage_flag_q;
  logic battery_removed_flag_q;
  logic battery_replaced_flag_q;
  logic valid_discharge_flag_q;
  logic capacity_inaccurate_flag_q;
  logic charging_q;
  logic overload_q;
  logic charge_rate_bit_q;
  logic [3:0] gauge_level_q;
  logic [3:0] temp_step_q;
  logic [CYC_W-1:0] cycle_count_q;
  logic update_pending_q;
  logic [bgsf_pkg::IRQ_W-1:0] irq_status_q;
  logic [bgsf_pkg::IRQ_W-1:0] irq_enable_q;
  logic [bgsf_pkg::IRQ_W-1:0] irq_event;
  logic [3:0] gauge_d;
  logic [3:0] temp_d;
  logic [CW-1:0] full_ref;
  logic [14:0] gauge_hits;
  logic [11:0] temp_hits;
  logic at_full;
  logic access;
  logic wr_take;
  logic rd_phase;
  logic [7:0] flags_one;
  logic [7:0] flags_two;

  default clocking bgsf_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic [3:0] count_ones(input logic [15:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  function automatic logic addr_is(input logic [7:0] a,
                                   input logic [7:0] off);
    return a == off;
  endfunction

  // apb: first access cycle loads read data, second completes the transfer
  assign access = psel && penable;
  assign rd_phase = access && !pready;
  assign wr_take = access && pready && pwrite;

  // gauge reference selected by the strap level
  assign full_ref = full_ref_programmed ? programmed_full_count
                                        : last_measured_discharge;
  assign at_full = (available_charge_count >= last_measured_discharge);

  // one comparator per sixteenth boundary; the step is how many are passed
  generate
    for (genvar k = 1; k < bgsf_pkg::GAUGE_STEPS; k++) begin : g_gauge
      localparam logic [CW+3:0] KMUL = (CW+4)'(k);
      assign gauge_hits[k-1] = {available_charge_count, 4'h0} >=
                               KMUL * {4'h0, full_ref};
    end
    for (genvar t = 0; t < 12; t++) begin : g_temp
      localparam int LIM = bgsf_pkg::TEMP_BASE_C +
                           t * bgsf_pkg::TEMP_BAND_C;
      localparam logic signed [8:0] LIM9 = 9'(LIM);
      assign temp_hits[t] = (t == 11) ? ($signed({temperature_c[7],
                            temperature_c}) > LIM9)
                          : ($signed({temperature_c[7], temperature_c})
                             >= LIM9);
    end
  endgenerate

  assign gauge_d = count_ones({1'b0, gauge_hits});
  assign temp_d = count_ones({4'h0, temp_hits});

  assign flags_one = {charging_q, battery_replaced_flag_q,
                      battery_removed_flag_q, capacity_inaccurate_flag_q,
                      valid_discharge_flag_q, 1'b0,
                      first_low_voltage_flag_q, final_low_voltage_flag_q};
  assign flags_two = {charge_rate_bit_q, 6'h00, overload_q};

  assign irq_event[bgsf_pkg::IRQ_FIRST_LOW] = below_first_threshold &&
                                              !first_low_voltage_flag_q;
  assign irq_event[bgsf_pkg::IRQ_FINAL_LOW] = below_final_threshold &&
                                              !final_low_voltage_flag_q;
  assign irq_event[bgsf_pkg::IRQ_REMOVED] = removed_condition &&
                                            !battery_removed_flag_q;
  assign irq_event[bgsf_pkg::IRQ_OVLD] = over_overload_threshold &&
                                         !overload_q;

  // low-voltage latches: a new crossing outranks the charge clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_low_voltage_flag_q <= 1'b0;
      final_low_voltage_flag_q <= 1'b0;
    end else begin
      if (below_first_threshold) begin
        first_low_voltage_flag_q <= 1'b1;
      end else if (charge_flowing_in) begin
        first_low_voltage_flag_q <= 1'b0;
      end
      if (below_final_threshold) begin
        final_low_voltage_flag_q <= 1'b1;
      end else if (charge_flowing_in) begin
        final_low_voltage_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charging_q <= 1'b0;
      overload_q <= 1'b0;
      charge_rate_bit_q <= 1'b0;
      gauge_level_q <= 4'h0;
      temp_step_q <= 4'h0;
    end else begin
      charging_q <= charge_flowing_in;
      overload_q <= over_overload_threshold;
      charge_rate_bit_q <= charge_flowing_in && fast_charge;
      gauge_level_q <= gauge_d;
      temp_step_q <= temp_d;
    end
  end

  // replaced flag starts set: a fresh start counts as a newly fitted pack
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      battery_removed_flag_q <= 1'b0;
      battery_replaced_flag_q <= bgsf_pkg::RST_REPLACED;
    end else begin
      if (removed_condition) begin
        battery_removed_flag_q <= 1'b1;
      end else if (valid_condition) begin
        battery_removed_flag_q <= 1'b0;
      end
      if (battery_removed_flag_q && valid_condition &&
          !removed_condition) begin
        battery_replaced_flag_q <= 1'b1;
      end else if (below_first_threshold ||
                   (charge_flowing_in && at_full)) begin
        battery_replaced_flag_q <= 1'b0;
      end
    end
  end

  // host write of the charge count wins over a same-cycle qualification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_discharge_flag_q <= 1'b0;
    end else if (wr_take && addr_is(paddr, bgsf_pkg::OFF_CHARGE_WRITE)) begin
      valid_discharge_flag_q <= 1'b0;
    end else if (charge_flowing_in && at_full) begin
      valid_discharge_flag_q <= 1'b1;
    end
  end

  // cycles counted at each start of charge; saturates rather than wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_count_q <= '0;
      update_pending_q <= 1'b0;
    end else begin
      if (capacity_updated) begin
        update_pending_q <= 1'b1;
      end else if (update_pending_q && at_full) begin
        update_pending_q <= 1'b0;
      end
      if (update_pending_q && at_full) begin
        cycle_count_q <= '0;
      end else if (charge_flowing_in && !charging_q &&
                   cycle_count_q != '1) begin
        cycle_count_q <= cycle_count_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capacity_inaccurate_flag_q <= 1'b0;
    end else begin
      capacity_inaccurate_flag_q <=
        (32'(cycle_count_q) >= bgsf_pkg::INACC_CYCLES);
    end
  end

  // sticky status: a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_q <= '0;
      irq_enable_q <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_take && addr_is(paddr, bgsf_pkg::OFF_IRQ_CLEAR)) begin
        irq_status_q <= (irq_status_q & ~pwdata[bgsf_pkg::IRQ_W-1:0])
                        | irq_event;
      end else begin
        irq_status_q <= irq_status_q | irq_event;
      end
      if (wr_take && addr_is(paddr, bgsf_pkg::OFF_IRQ_ENABLE)) begin
        irq_enable_q <= pwdata[bgsf_pkg::IRQ_W-1:0];
      end
      irq <= |(irq_status_q & irq_enable_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charge_load <= 1'b0;
      charge_load_value <= '0;
    end else begin
      charge_load <= wr_take && addr_is(paddr, bgsf_pkg::OFF_CHARGE_WRITE);
      if (wr_take && addr_is(paddr, bgsf_pkg::OFF_CHARGE_WRITE)) begin
        charge_load_value <= pwdata[CW-1:0];
      end
    end
  end

  // reads only sample state; no register changes as a side effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= bgsf_pkg::WORD_ZERO;
      pslverr <= 1'b0;
    end else if (rd_phase) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= bgsf_pkg::WORD_ZERO;
      if (addr_is(paddr, bgsf_pkg::OFF_FLAGS_ONE)) begin
        prdata[7:0] <= flags_one;
      end else if (addr_is(paddr, bgsf_pkg::OFF_FLAGS_TWO)) begin
        prdata[7:0] <= flags_two;
      end else if (addr_is(paddr, bgsf_pkg::OFF_TEMP_GAUGE)) begin
        prdata[7:0] <= {temp_step_q, gauge_level_q};
      end else if (addr_is(paddr, bgsf_pkg::OFF_CYCLES)) begin
        prdata[CYC_W-1:0] <= cycle_count_q;
      end else if (addr_is(paddr, bgsf_pkg::OFF_CHARGE_WRITE)) begin
        prdata[CW-1:0] <= charge_load_value;
      end else if (addr_is(paddr, bgsf_pkg::OFF_IRQ_STATUS)) begin
        prdata[bgsf_pkg::IRQ_W-1:0] <= irq_status_q;
      end else if (addr_is(paddr, bgsf_pkg::OFF_IRQ_ENABLE)) begin
        prdata[bgsf_pkg::IRQ_W-1:0] <= irq_enable_q;
      end else if (!addr_is(paddr, bgsf_pkg::OFF_IRQ_CLEAR)) begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  AST_FIRST_LOW_SET: assert property (
    below_first_threshold |=> first_low_voltage_flag_q)
    else $error("first low flag not set");
  AST_FIRST_LOW_CLR: assert property (
    charge_flowing_in && !below_first_threshold
    |=> !first_low_voltage_flag_q)
    else $error("first low flag not cleared");
  AST_FINAL_LOW_HOLD: assert property (
    final_low_voltage_flag_q && !charge_flowing_in
    |=> final_low_voltage_flag_q)
    else $error("final low flag dropped");
  AST_FINAL_LOW_SET: assert property (
    below_final_threshold |=> final_low_voltage_flag_q)
    else $error("final low flag not set");
  AST_GAUGE_RANGE: assert property (
    full_ref != '0 && available_charge_count < full_ref
    |=> gauge_level_q < bgsf_pkg::GAUGE_MAX ||
        $past(available_charge_count) >=
        ($past(full_ref) - ($past(full_ref) >> 4)))
    else $error("gauge step above capacity");
  AST_TEMP_MAX: assert property (
    temperature_c > 8'sh50 |=> temp_step_q == bgsf_pkg::TEMP_MAX)
    else $error("hot temperature step wrong");
  AST_OVLD: assert property (
    over_overload_threshold |=> flags_two[bgsf_pkg::F2_OVLD])
    else $error("overload not shown");
  AST_REMOVED: assert property (
    removed_condition |=> battery_removed_flag_q)
    else $error("removed flag not set");
  AST_CHARGE_WRITE: assert property (
    wr_take && paddr == bgsf_pkg::OFF_CHARGE_WRITE
    |=> !valid_discharge_flag_q ##0 charge_load)
    else $error("charge write did not disqualify");
  AST_CAP_INACC: assert property (
    cycle_count_q >= CYC_W'(bgsf_pkg::INACC_CYCLES)
    |=> capacity_inaccurate_flag_q)
    else $error("capacity inaccurate not set");
  AST_READ_STABLE: assert property (
    access && !pwrite
    |=> $stable(irq_enable_q) && $stable(charge_load_value))
    else $error("read altered state");
  AST_APB_DONE: assert property (
    rd_phase |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  COV_FINAL_LOW: cover property (
    final_low_voltage_flag_q ##1 !final_low_voltage_flag_q);
  COV_REPLACE: cover property (
    battery_removed_flag_q ##[1:20] battery_replaced_flag_q);
  COV_CAP_INACC: cover property ($rose(capacity_inaccurate_flag_q));
  COV_IRQ: cover property ($rose(irq));
endmodule

// ==== bgsf_status_flags_tb_top.sv ====
/*
  Self-checking testbench for the battery gauge status and flag block.
  Assumes the APB host model drives the register port; the bench drives
  the analog and counter levels directly.
*/
`timescale 1ns/100ps
module bgsf_status_flags_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic irq, charge_load, capacity_updated, full_ref_programmed;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic below_first_threshold, below_final_threshold, fast_charge;
  logic over_overload_threshold, charge_flowing_in, err;
  logic removed_condition, valid_condition;
  logic [15:0] available_charge_count, last_measured_discharge;
  logic [15:0] programmed_full_count, charge_load_value;
  logic signed [7:0] temperature_c;
  int n_mismatch, checks, cycles, loads;

  bgsf_status_flags bgsf_status_flags_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .below_first_threshold, .below_final_threshold,
    .over_overload_threshold, .charge_flowing_in, .fast_charge,
    .removed_condition, .valid_condition, .capacity_updated,
    .full_ref_programmed, .available_charge_count,
    .last_measured_discharge, .programmed_full_count, .temperature_c,
    .irq, .charge_load, .charge_load_value);

  bgsf_apb_host bgsf_apb_host_i (.pclk, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run needs about 320 cycles
  always @(posedge pclk) begin
    cycles++;
    if (charge_load === 1'b1) loads++;
    if (cycles == 6000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bgsf_apb_host_i.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rc(input string nm, input logic [7:0] a,
                    input logic [31:0] exp);
    bgsf_apb_host_i.xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(nm, exp, rd);
  endtask

  task automatic settle;
    repeat (3) @(posedge pclk);
  endtask

  task automatic chg(input int n);
    repeat (n) begin
      @(posedge pclk);
      charge_flowing_in <= 1'b1;
      @(posedge pclk);
      charge_flowing_in <= 1'b0;
    end
  endtask

  task automatic gt(input logic s, input logic [15:0] n,
                    input logic signed [7:0] t, input logic [7:0] e);
    @(posedge pclk);
    full_ref_programmed <= s;
    available_charge_count <= n;
    temperature_c <= t;
    rc("temp_and_gauge_reg", bgsf_pkg::OFF_TEMP_GAUGE, {24'h000000, e});
  endtask

  initial begin
    presetn = 1'b0;
    {below_first_threshold, below_final_threshold, fast_charge} = 3'h0;
    {over_overload_threshold, charge_flowing_in, removed_condition} = 3'h0;
    {capacity_updated, full_ref_programmed} = 2'h0;
    valid_condition = 1'b1;
    available_charge_count = 16'h0000;
    last_measured_discharge = 16'h00A0;
    programmed_full_count = 16'h0020;
    temperature_c = 8'h19;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h40);
    rc("flags_reg_two", bgsf_pkg::OFF_FLAGS_TWO, 32'h00);
    $display("test reset done");

    wr(bgsf_pkg::OFF_IRQ_ENABLE, 32'h0000_000F);
    @(posedge pclk);
    below_first_threshold <= 1'b1;
    @(posedge pclk);
    below_first_threshold <= 1'b0;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h02);
    rc("irq_status", bgsf_pkg::OFF_IRQ_STATUS, 32'h01);
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge pclk);
    below_final_threshold <= 1'b1;
    @(posedge pclk);
    below_final_threshold <= 1'b0;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h03);
    wr(bgsf_pkg::OFF_IRQ_CLEAR, 32'h0000_000F);
    settle();
    rc("irq_status", bgsf_pkg::OFF_IRQ_STATUS, 32'h00);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge pclk);
    charge_flowing_in <= 1'b1;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h80);
    @(posedge pclk);
    charge_flowing_in <= 1'b0;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h00);
    $display("test low voltage done");

    wr(bgsf_pkg::OFF_IRQ_ENABLE, 32'h0000_0000);
    @(posedge pclk);
    {over_overload_threshold, fast_charge, charge_flowing_in} <= 3'h7;
    rc("flags_reg_two", bgsf_pkg::OFF_FLAGS_TWO, 32'h81);
    chk("irq", 32'h0, {31'h0, irq});
    wr(bgsf_pkg::OFF_IRQ_ENABLE, 32'h0000_0008);
    settle();
    chk("irq", 32'h1, {31'h0, irq});
    wr(bgsf_pkg::OFF_IRQ_CLEAR, 32'h0000_0008);
    settle();
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge pclk);
    {over_overload_threshold, fast_charge} <= 2'h0;
    rc("flags_reg_two", bgsf_pkg::OFF_FLAGS_TWO, 32'h00);
    @(posedge pclk);
    charge_flowing_in <= 1'b0;
    $display("test overload done");

    gt(1'b0, 16'h0000, 8'hE1, 8'h00);
    gt(1'b0, 16'h000A, 8'hE2, 8'h11);
    gt(1'b0, 16'h009F, 8'h50, 8'hBF);
    gt(1'b0, 16'h00A0, 8'h51, 8'hCF);
    gt(1'b1, 16'h0010, 8'h19, 8'h68);
    $display("test gauge done");

    @(posedge pclk);
    removed_condition <= 1'b1;
    valid_condition <= 1'b0;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h20);
    @(posedge pclk);
    removed_condition <= 1'b0;
    valid_condition <= 1'b1;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h40);
    $display("test removal done");

    @(posedge pclk);
    available_charge_count <= 16'h00A0;
    charge_flowing_in <= 1'b1;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h88);
    @(posedge pclk);
    charge_flowing_in <= 1'b0;
    available_charge_count <= 16'h0000;
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h08);
    wr(bgsf_pkg::OFF_CHARGE_WRITE, 32'h0000_1234);
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h00);
    chk("charge_load_value", 32'h1234, {16'h0000, charge_load_value});
    chk("charge_load", 32'h1, loads);
    rc("charge_write", bgsf_pkg::OFF_CHARGE_WRITE, 32'h1234);
    $display("test valid discharge done");

    chg(60);
    rc("cycle_count", bgsf_pkg::OFF_CYCLES, 32'h3F);
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h00);
    chg(1);
    rc("cycle_count", bgsf_pkg::OFF_CYCLES, 32'h40);
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h10);
    @(posedge pclk);
    available_charge_count <= 16'h00A0;
    capacity_updated <= 1'b1;
    @(posedge pclk);
    capacity_updated <= 1'b0;
    settle();
    rc("cycle_count", bgsf_pkg::OFF_CYCLES, 32'h00);
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h00);
    $display("test cycles done");

    bgsf_apb_host_i.xfer(1'b0, 8'h20, 32'h0000_0000, rd, err);
    chk("unmapped_err", 32'h1, {31'h0, err});
    chk("unmapped_data", 32'h0000_0000, rd);
    wr(bgsf_pkg::OFF_FLAGS_ONE, 32'h0000_00FF);
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h00);
    rc("flags_reg_one", bgsf_pkg::OFF_FLAGS_ONE, 32'h00);
    rc("irq_enable", bgsf_pkg::OFF_IRQ_ENABLE, 32'h08);
    rc("irq_clear", bgsf_pkg::OFF_IRQ_CLEAR, 32'h00);
    chk("irq_clear_err", 32'h0, {31'h0, err});
    $display("test access done");
    results();
  end
endmodule
